// *** wdrt_watchdog_reset_timer.sv ***
// Watchdog reset timer with one bit-addressable control register on the core's SFR port.
// Assumes a byte write port and a bit set/clear port driven by the core, both synchronous.
`timescale 1ns/10ps
`default_nettype none
`include "wdrt_params.svh"

module wdrt_watchdog_reset_timer #(
    parameter int CLK_HZ = `WDRT_CLK_HZ,
    parameter int CNT_WIDTH = `WDRT_CNT_WIDTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic bit_wr,
    input wire logic [2:0] bit_sel,
    input wire logic bit_val,
    output logic [7:0] sfr_rdata,
    output logic system_reset
);
    import wdrt_pkg::*;

    // ********************************
    // Elaboration checks
    // ********************************
    // Field positions and the doubling table are laid out for a 16-bit counter.
    if (CNT_WIDTH != 16) begin : g_bad_width
        $error("Counter width must be 16.");
    end
    // Below this rate a millisecond is shorter than one clock cycle.
    if (CLK_HZ < 1000) begin : g_bad_clock
        $error("Clock rate too low for the millisecond base.");
    end

    // ********************************
    // Derived timing
    // ********************************
    // The shortest timeout spans 512 counter steps, so one step is the base period over 512.
    // Longer prescale codes raise the terminal count rather than the step length, so one
    // free-running tick serves every code; a timeout may therefore come up to a tick early.
    localparam longint BASE_CYCLES = longint'(CLK_HZ) * `WDRT_BASE_MS / 1000;
    localparam longint TICK_LONG = BASE_CYCLES >> `WDRT_STEP_SHIFT;
    localparam int TICK_CYCLES = (TICK_LONG < 1) ? 1 : int'(TICK_LONG);

    // ********************************
    // Declarations
    // ********************************
    wdrt_state_t st;
    wdrt_state_t next_st;
    logic byte_hit;
    logic bit_hit;
    logic wr_hit;
    logic [7:0] bit_mask;
    logic [7:0] merged;
    logic [7:0] wr_val;
    logic ref1_rise;
    logic ref2_rise;
    logic refresh_done;
    logic tick;
    logic [15:0] terminal;
    logic timeout;

    // ********************************
    // Address decode
    // ********************************
    // A byte write wins over a bit write that arrives in the same cycle.
    always_comb begin
        byte_hit = 1'b0;
        bit_hit = 1'b0;
        if (sfr_addr != `WDRT_CTRL_ADDR) begin
            byte_hit = 1'b0;
        end else if (sfr_wr) begin
            byte_hit = 1'b1;
        end else if (bit_wr) begin
            bit_hit = 1'b1;
        end
    end

    assign wr_hit = byte_hit | bit_hit;

    // ********************************
    // Per-bit write merge
    // ********************************
    // A bit write touches only the selected bit, so the other fields keep their values.
    for (genvar b = 0; b < 8; b++) begin : g_merge
        assign bit_mask[b] = bit_hit && (bit_sel == 3'(b));
        if (b == `WDRT_UNUSED_BIT) begin : g_unused
            // The unused bit reads zero whatever is written.
            assign merged[b] = 1'b0;
        end else if (b == `WDRT_STAT_BIT) begin : g_status
            // A one written leaves the flag as it was; only a zero clears it.
            assign merged[b] = st.ctrl[b]
                & (byte_hit ? sfr_wdata[b] : (!bit_mask[b] | bit_val));
        end else begin : g_plain
            assign merged[b] = byte_hit ? sfr_wdata[b] : (bit_mask[b] ? bit_val : st.ctrl[b]);
        end
    end

    // ********************************
    // Refresh edges
    // ********************************
    // Only a rising refresh bit counts, so a bit left set cannot refresh twice.
    always_comb begin
        ref1_rise = wr_hit && merged[`WDRT_REF1_BIT] && !st.ctrl[`WDRT_REF1_BIT];
        ref2_rise = wr_hit && merged[`WDRT_REF2_BIT] && !st.ctrl[`WDRT_REF2_BIT];
    end

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        next_st = st;
        next_st.sys_reset = 1'b0;
        refresh_done = 1'b0;
        wr_val = merged;
        tick = 1'b0;
        terminal = 16'h0000;
        timeout = 1'b0;

        // The first bit arms, the second completes; the second alone is ignored.
        case (st.refresh)
            WDRT_IDLE: begin
                if (ref1_rise) begin
                    next_st.refresh = WDRT_ARMED;
                end
            end
            WDRT_ARMED: begin
                if (ref2_rise && merged[`WDRT_REF1_BIT]) begin
                    refresh_done = 1'b1;
                    next_st.refresh = WDRT_IDLE;
                end else if (!merged[`WDRT_REF1_BIT]) begin
                    // Clearing the first bit by hand withdraws the armed refresh.
                    next_st.refresh = WDRT_IDLE;
                end
            end
            default: begin
                next_st.refresh = WDRT_IDLE;
            end
        endcase

        // Refresh bits act as strobes and self-clear once the pair completes.
        if (refresh_done) begin
            wr_val[`WDRT_REF1_BIT] = 1'b0;
            wr_val[`WDRT_REF2_BIT] = 1'b0;
        end
        next_st.ctrl = wr_val;

        // The step tick runs free; a refresh does not realign it.
        tick = (st.tick_cnt == 32'(TICK_CYCLES - 1));
        if (tick) begin
            next_st.tick_cnt = 32'h0000_0000;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 32'h0000_0001;
        end

        // Each prescale step doubles the terminal count.
        terminal = `WDRT_TERM_BASE << st.ctrl[`WDRT_PRE_MSB:`WDRT_PRE_LSB];

        if (!next_st.ctrl[`WDRT_EN_BIT]) begin
            // Disabling also drops a half-done refresh, so a later enable starts clean.
            next_st.wd_cnt = 16'h0000;
            next_st.ctrl[`WDRT_REF1_BIT] = 1'b0;
            next_st.ctrl[`WDRT_REF2_BIT] = 1'b0;
            next_st.refresh = WDRT_IDLE;
        end else if (refresh_done) begin
            next_st.wd_cnt = 16'h0000;
        end else if (st.ctrl[`WDRT_EN_BIT] && tick) begin
            if (st.wd_cnt >= terminal) begin
                timeout = 1'b1;
                next_st.wd_cnt = 16'h0000;
            end else begin
                next_st.wd_cnt = st.wd_cnt + 16'h0001;
            end
        end

        if (timeout) begin
            next_st.sys_reset = 1'b1;
            // Setting wins over a clear written in the same cycle.
            next_st.ctrl[`WDRT_STAT_BIT] = 1'b1;
            next_st.ctrl[`WDRT_REF1_BIT] = 1'b0;
            next_st.ctrl[`WDRT_REF2_BIT] = 1'b0;
            next_st.refresh = WDRT_IDLE;
        end
    end

    // ********************************
    // State register
    // ********************************
    // External reset clears the whole register, status included; the pulse this block
    // sends out is not wired back here, so status survives it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '{ctrl: `WDRT_CTRL_RESET, refresh: WDRT_IDLE, tick_cnt: 32'h0,
                     wd_cnt: 16'h0000, sys_reset: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign sfr_rdata = st.ctrl;
    assign system_reset = st.sys_reset;

endmodule
`default_nettype wire

// *** wdrt_params.svh ***
// Register offsets, field positions, reset values and timing counts of the watchdog.
// Assumes inclusion by the watchdog package and module only.
`ifndef WDRT_PARAMS_SVH
`define WDRT_PARAMS_SVH

`define WDRT_CTRL_ADDR 8'hC0
`define WDRT_CTRL_RESET 8'h00
`define WDRT_PRE_MSB 7
`define WDRT_PRE_LSB 5
`define WDRT_REF1_BIT 3
`define WDRT_REF2_BIT 2
`define WDRT_STAT_BIT 1
`define WDRT_EN_BIT 0
`define WDRT_CLK_HZ 100000000
`define WDRT_BASE_MS 16
`define WDRT_CNT_WIDTH 16
`define WDRT_STEP_SHIFT 9
`define WDRT_TERM_BASE 16'h01FF
`define WDRT_UNUSED_BIT 4

`endif

// *** wdrt_pkg.sv ***
// Types shared by the watchdog reset timer.
// Assumes the params header sits in the same folder.
`include "wdrt_params.svh"

package wdrt_pkg;

    typedef enum logic [0:0] {
        WDRT_IDLE = 1'b0,
        WDRT_ARMED = 1'b1
    } wdrt_refresh_t;

    typedef struct packed {
        logic [7:0] ctrl;
        wdrt_refresh_t refresh;
        logic [31:0] tick_cnt;
        logic [15:0] wd_cnt;
        logic sys_reset;
    } wdrt_state_t;

endpackage

// *** wdrt_asserts.sv ***
// Checker for the watchdog control register and its reset pulse.
// Assumes it is bound to the watchdog top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module wdrt_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic bit_wr,
    input wire logic [2:0] bit_sel,
    input wire logic bit_val,
    input wire logic [7:0] sfr_rdata,
    input wire logic system_reset
);
    logic hit;
    logic bw;
    assign hit = sfr_addr == 8'hC0;
    assign bw = hit && bit_wr && !sfr_wr;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_pulse_single: assert property (system_reset |=> !system_reset)
        else $error("reset pulse too long");
    chk_status_trip: assert property (
        system_reset |-> sfr_rdata[1] && sfr_rdata[3:2] == 2'b00)
        else $error("status or refresh bits wrong at timeout");
    chk_off_quiet: assert property (!sfr_rdata[0] |=> !system_reset)
        else $error("reset while disabled");
    chk_byte_write: assert property (
        hit && sfr_wr |=> sfr_rdata[7:5] == $past(sfr_wdata[7:5])
        && sfr_rdata[0] == $past(sfr_wdata[0])) else $error("byte write lost");
    chk_bit_write: assert property (
        bw && bit_sel inside {3'h0, 3'h5, 3'h6, 3'h7}
        |=> sfr_rdata[$past(bit_sel)] == $past(bit_val)) else $error("bit write lost");
    chk_status_clear: assert property (
        bw && bit_sel == 3'h1 && !bit_val
        |=> !sfr_rdata[1] || system_reset) else $error("status not cleared");
    chk_pair_done: assert property (
        bw && bit_sel == 3'h2 && bit_val && sfr_rdata[3:2] == 2'b10
        |=> sfr_rdata[3:2] == 2'b00) else $error("refresh pair not taken");
    chk_foreign_addr: assert property (
        !hit && (sfr_wr || bit_wr)
        |=> $stable(sfr_rdata[7:5]) && $stable(sfr_rdata[0])) else $error("foreign write taken");
    cov_timeout: cover property (system_reset);
    cov_second_bit: cover property (bw && bit_sel == 3'h2);
    cov_byte_write: cover property (hit && sfr_wr);
    cov_pair_done: cover property (bw && bit_sel == 3'h2 && bit_val && sfr_rdata[3:2] == 2'b10);
endmodule
bind wdrt_watchdog_reset_timer wdrt_asserts i_wdrt_asserts (.clk(clk), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .bit_wr(bit_wr),
    .bit_sel(bit_sel), .bit_val(bit_val), .sfr_rdata(sfr_rdata), .system_reset(system_reset));
`default_nettype wire

// *** wdrt_watchdog_reset_timer_tb.sv ***
// Self-checking bench for the watchdog reset timer.
// Assumes CLK_HZ is lowered so one tick is two cycles and 16 ms is about 1024 cycles.
`timescale 1ns/10ps
`default_nettype none
module wdrt_watchdog_reset_timer_tb;
    logic clk = 0, rst = 1, sfr_wr = 0, bit_wr = 0, bit_val = 0, system_reset;
    logic [7:0] sfr_addr = 8'hC0, sfr_wdata = 8'h00, sfr_rdata;
    logic [2:0] bit_sel = 3'h0;
    int mismatches = 0, n_checks = 0, t;
    wdrt_watchdog_reset_timer #(.CLK_HZ(64000)) i_wdrt_watchdog_reset_timer (.clk(clk),
        .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .bit_wr(bit_wr),
        .bit_sel(bit_sel), .bit_val(bit_val), .sfr_rdata(sfr_rdata), .system_reset(system_reset));
    initial forever #5 clk = ~clk;
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chk_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
        @(negedge clk) {sfr_addr, sfr_wr} = {8'hC0, 1'b0};
    endtask
    task bs(input logic [2:0] s, input logic v);
        @(negedge clk) {bit_sel, bit_val, bit_wr} = {s, v, 1'b1};
        @(negedge clk) bit_wr = 0;
    endtask
    // Records in t the cycle of the first reset pulse, zero when none came.
    task run(input int n);
        t = 0;
        for (int i = 1; i <= n; i++) begin
            @(posedge clk);
            #1 if (system_reset === 1'b1 && t == 0) t = i;
        end
    endtask
    initial begin
        #300000 mismatches++;
        give_verdict;
    end
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk) rst = 0;
        chk("ctrl", 8'h00, sfr_rdata);
        wr(8'hC1, 8'hFF);
        chk("ctrl", 8'h00, sfr_rdata);
        wr(8'hC0, 8'hE1);
        chk("ctrl", 8'hE1, sfr_rdata);
        wr(8'hC0, 8'h00);
        $display("registers done");
        bs(3'h0, 1'b1);
        run(1100);
        chk_bit("tmo16", 1'b1, t >= 1015 && t <= 1035);
        chk("ctrl", 8'h03, sfr_rdata);
        repeat (3) begin
            run(700);
            chk_bit("refresh", 1'b1, t == 0);
            bs(3'h3, 1'b1);
            bs(3'h2, 1'b1);
            chk("ctrl", 8'h03, sfr_rdata);
        end
        run(700);
        chk_bit("refresh", 1'b1, t == 0);
        bs(3'h2, 1'b1);
        run(700);
        chk_bit("lone2", 1'b1, t >= 300 && t <= 340);
        bs(3'h1, 1'b0);
        chk_bit("status", 1'b0, sfr_rdata[1]);
        run(700);
        bs(3'h0, 1'b0);
        run(2100);
        chk_bit("off", 1'b1, t == 0);
        bs(3'h0, 1'b1);
        run(1100);
        chk_bit("restart", 1'b1, t >= 1015 && t <= 1035);
        wr(8'hC0, 8'h20);
        bs(3'h0, 1'b1);
        run(2200);
        chk_bit("tmo32", 1'b1, t >= 2035 && t <= 2065);
        $display("timeouts done");
        give_verdict;
    end
endmodule
`default_nettype wire
